// ---- logic/adcs_pkg.sv ----
package adcs_pkg;
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_CFG    = 8'h04;
    localparam logic [7:0] OFS_RES_HI = 8'h08;
    localparam logic [7:0] OFS_RES_LO = 8'h0C;
    localparam logic [7:0] OFS_ASEL   = 8'h10;
    localparam logic [7:0] OFS_DIR_A  = 8'h14;
    localparam logic [7:0] OFS_DIR_B  = 8'h18;
    localparam logic [7:0] OFS_PINS_A = 8'h1C;
    localparam logic [7:0] OFS_PINS_B = 8'h20;
    localparam logic [7:0] OFS_STAT   = 8'h24;

    localparam logic [5:0]  RST_ASEL  = 6'h3F;
    localparam logic [15:0] RST_OE    = 16'h0000;
    localparam logic [15:0] RST_OUT   = 16'h0000;
    localparam logic [7:0]  RST_CTRL  = 8'h00;
    localparam logic [7:0]  RST_CFG   = 8'h00;

    localparam logic [8:0]  DIV_00    = 9'h002;
    localparam logic [8:0]  DIV_01    = 9'h008;
    localparam logic [8:0]  DIV_10    = 9'h020;
    localparam logic [8:0]  RC_UNITS  = 9'h002;
    localparam int          REF_SHIFT = 3;
    localparam logic [1:0]  CS_RC     = 2'h3;
    localparam logic [3:0]  PER_FIRST = 4'h1;
    localparam logic [3:0]  PER_LAST  = 4'hD;
    localparam logic [11:0] TRIAL_MSB = 12'h800;
    localparam int          VREFP_PIN = 3;
    localparam int          VREFN_PIN = 2;

    typedef struct packed {
        logic [1:0] clk_sel;
        logic [2:0] chan;
        logic       go;
        logic       spare;
        logic       on;
    } adcs_ctrl_t;

    typedef struct packed {
        logic       justify;
        logic [2:0] ref_cfg;
        logic [3:0] spare;
    } adcs_cfg_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CONV = 2'b01,
        ST_TAIL = 2'b10
    } adcs_state_t;
endpackage : adcs_pkg

// ---- logic/adcs_top.sv ----
`timescale 1ns/100ps
module adcs_top (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic [15:0] port_pin_in,
    output logic      [15:0] port_pin_out,
    output logic      [15:0] port_pin_oe,
    output logic      [15:0] port_ibuf_en,
    input  wire logic        rc_osc,
    input  wire logic        cmp_in,
    output logic      [2:0]  ana_chan,
    output logic      [11:0] dac_code,
    output logic             conv_busy,
    output logic             conversion_done_flag
);
    adcs_pkg::adcs_ctrl_t  ctrl_r, ctrl_nxt, wctrl;
    adcs_pkg::adcs_cfg_t   cfg_r;
    adcs_pkg::adcs_state_t st_r, st_nxt;
    logic [7:0]  addr_q;
    logic        wr_q, rd_q;
    logic [31:0] hrdata_r, rdata;
    logic        hreadyout_r, hresp_r;
    logic [5:0]  ana_sel_r;
    logic [15:0] oe_r, out_r, ibuf_r;
    logic [15:0] pin_s1, pin_s2;
    logic        rc_s1, rc_s2, rc_s3;
    logic [8:0]  ph_r, ph_nxt;
    logic [3:0]  per_r, per_nxt;
    logic [11:0] trial_r, trial_nxt, resv_r, resv_nxt, dac_r;
    logic        flag_r, done_set, res_we;
    logic [7:0]  res_hi_r, res_lo_r;

    // Bus decode
    wire logic sel = hsel & htrans[1] & hready;
    wire logic ctrl_we  = wr_q & (addr_q == adcs_pkg::OFS_CTRL);
    wire logic cfg_we   = wr_q & (addr_q == adcs_pkg::OFS_CFG);
    wire logic asel_we  = wr_q & (addr_q == adcs_pkg::OFS_ASEL);
    wire logic dira_we  = wr_q & (addr_q == adcs_pkg::OFS_DIR_A);
    wire logic dirb_we  = wr_q & (addr_q == adcs_pkg::OFS_DIR_B);
    wire logic pina_we  = wr_q & (addr_q == adcs_pkg::OFS_PINS_A);
    wire logic pinb_we  = wr_q & (addr_q == adcs_pkg::OFS_PINS_B);
    wire logic stat_we  = wr_q & (addr_q == adcs_pkg::OFS_STAT);

    // Reference decode
    wire logic [2:0] vref = cfg_r.ref_cfg;
    wire logic int_ref = (vref == 3'h2) | (vref == 3'h4) |
                         (vref == 3'h6) | (vref == 3'h7);
    wire logic ext_hi = (vref == 3'h1) | (vref == 3'h3);
    wire logic ext_lo = (vref == 3'h1) | (vref == 3'h5);

    // Channels 0-3 sit on port A pins 0-3, channels 4-5 on port B pins 0-1
    wire logic [15:0] ana_map = {6'h00, ana_sel_r[5:4], 4'h0, ana_sel_r[3:0]};
    wire logic [15:0] ref_map =
        (16'(ext_hi) << adcs_pkg::VREFP_PIN) |
        (16'(ext_lo) << adcs_pkg::VREFN_PIN);
    wire logic [15:0] eff_an = ana_map | ref_map;
    wire logic [15:0] pin_rd = pin_s2 & ~eff_an;

    // Conversion clock selection
    wire logic rc_mode = ctrl_r.clk_sel == adcs_pkg::CS_RC;
    wire logic rc_edge = rc_s2 ^ rc_s3;
    wire logic [8:0] base =
        rc_mode                  ? adcs_pkg::RC_UNITS :
        (ctrl_r.clk_sel == 2'h0) ? adcs_pkg::DIV_00 :
        (ctrl_r.clk_sel == 2'h1) ? adcs_pkg::DIV_01 :
                                   adcs_pkg::DIV_10;
    wire logic [8:0] period = int_ref ? (base << adcs_pkg::REF_SHIFT)
                                      : base;
    wire logic [8:0] half = period >> 1;
    // RC mode counts synchronised rc_osc edges of both polarities
    wire logic unit_ev = rc_mode ? rc_edge : 1'b1;
    wire logic ph_wrap = ph_r == (period - 9'h001);
    // Go drops half a period into the fourteenth period
    wire logic ph_half = (ph_r + 9'h001) == half;
    wire logic busy = st_r != adcs_pkg::ST_IDLE;

    // Go is ignored in the write that also turns the converter on
    assign wctrl = adcs_pkg::adcs_ctrl_t'(hwdata[7:0]);
    wire logic start = ctrl_we & wctrl.go & wctrl.on & ctrl_r.on &
                       ~busy;
    wire logic abort = busy & ctrl_we & (~wctrl.go | ~wctrl.on);

    always_comb begin
        st_nxt    = st_r;
        ph_nxt    = ph_r;
        per_nxt   = per_r;
        trial_nxt = trial_r;
        resv_nxt  = resv_r;
        done_set  = 1'b0;
        res_we    = 1'b0;
        case (st_r)
            adcs_pkg::ST_IDLE: begin
                if (start) begin
                    st_nxt    = adcs_pkg::ST_CONV;
                    ph_nxt    = 9'h000;
                    per_nxt   = adcs_pkg::PER_FIRST;
                    trial_nxt = 12'h000;
                    resv_nxt  = 12'h000;
                end
            end
            adcs_pkg::ST_CONV: begin
                if (abort) begin
                    st_nxt = adcs_pkg::ST_IDLE;
                    res_we = 1'b1;
                end else if (unit_ev) begin
                    ph_nxt = ph_wrap ? 9'h000 : ph_r + 9'h001;
                    if (ph_wrap) begin
                        per_nxt   = per_r + 4'h1;
                        resv_nxt  = resv_r | (trial_r & {12{cmp_in}});
                        trial_nxt = (per_r == adcs_pkg::PER_FIRST) ?
                                    adcs_pkg::TRIAL_MSB : (trial_r >> 1);
                        if (per_r == adcs_pkg::PER_LAST) begin
                            st_nxt   = adcs_pkg::ST_TAIL;
                            done_set = 1'b1;
                            res_we   = 1'b1;
                        end
                    end
                end
            end
            adcs_pkg::ST_TAIL: begin
                // An abort here rewrites the same final result
                if (abort) begin
                    st_nxt = adcs_pkg::ST_IDLE;
                    res_we = 1'b1;
                end else if (unit_ev) begin
                    ph_nxt = ph_wrap ? 9'h000 : ph_r + 9'h001;
                    if (ph_half) begin
                        st_nxt = adcs_pkg::ST_IDLE;
                    end
                end
            end
            default: begin
                st_nxt = adcs_pkg::ST_IDLE;
            end
        endcase
    end

    always_comb begin
        ctrl_nxt = ctrl_r;
        if (ctrl_we) begin
            ctrl_nxt = wctrl;
        end
        ctrl_nxt.spare = 1'b0;
        ctrl_nxt.go    = st_nxt != adcs_pkg::ST_IDLE;
    end

    // Read data, sampled in the single wait cycle of a read
    always_comb begin
        rdata = 32'h0000_0000;
        if (addr_q == adcs_pkg::OFS_CTRL) begin
            rdata[7:0] = ctrl_r;
        end else if (addr_q == adcs_pkg::OFS_CFG) begin
            rdata[7:0] = cfg_r;
        end else if (addr_q == adcs_pkg::OFS_RES_HI) begin
            rdata[7:0] = res_hi_r;
        end else if (addr_q == adcs_pkg::OFS_RES_LO) begin
            rdata[7:0] = res_lo_r;
        end else if (addr_q == adcs_pkg::OFS_ASEL) begin
            rdata[5:0] = ana_sel_r;
        end else if (addr_q == adcs_pkg::OFS_DIR_A) begin
            rdata[7:0] = ~oe_r[7:0];
        end else if (addr_q == adcs_pkg::OFS_DIR_B) begin
            rdata[7:0] = ~oe_r[15:8];
        end else if (addr_q == adcs_pkg::OFS_PINS_A) begin
            rdata[7:0] = pin_rd[7:0];
        end else if (addr_q == adcs_pkg::OFS_PINS_B) begin
            rdata[7:0] = pin_rd[15:8];
        end else if (addr_q == adcs_pkg::OFS_STAT) begin
            rdata[0] = flag_r;
        end
    end

    // Bus slave: writes are zero-wait, reads take one wait cycle
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            addr_q      <= 8'h00;
            wr_q        <= 1'b0;
            rd_q        <= 1'b0;
            hreadyout_r <= 1'b1;
            hresp_r     <= 1'b0;
            hrdata_r    <= 32'h0000_0000;
        end else begin
            if (sel) begin
                addr_q <= haddr[7:0];
            end
            wr_q        <= sel & hwrite;
            rd_q        <= sel & ~hwrite;
            hreadyout_r <= ~(sel & ~hwrite);
            hresp_r     <= 1'b0;
            if (rd_q) begin
                hrdata_r <= rdata;
            end
        end
    end

    // Pin and RC clock synchronisers
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pin_s1 <= 16'h0000;
            pin_s2 <= 16'h0000;
            rc_s1  <= 1'b0;
            rc_s2  <= 1'b0;
            rc_s3  <= 1'b0;
        end else begin
            pin_s1 <= port_pin_in;
            pin_s2 <= pin_s1;
            rc_s1  <= rc_osc;
            rc_s2  <= rc_s1;
            rc_s3  <= rc_s2;
        end
    end

    // Port configuration; output drive ignores analog select
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ana_sel_r <= adcs_pkg::RST_ASEL;
            oe_r      <= adcs_pkg::RST_OE;
            out_r     <= adcs_pkg::RST_OUT;
            ibuf_r    <= 16'h0000;
        end else begin
            if (asel_we) begin
                ana_sel_r <= hwdata[5:0];
            end
            if (dira_we) begin
                oe_r[7:0] <= ~hwdata[7:0];
            end
            if (dirb_we) begin
                oe_r[15:8] <= ~hwdata[7:0];
            end
            if (pina_we) begin
                out_r[7:0] <= hwdata[7:0];
            end
            if (pinb_we) begin
                out_r[15:8] <= hwdata[7:0];
            end
            // Buffer enables lag the configuration by one cycle
            ibuf_r <= ~eff_an;
        end
    end

    // Sequencer and control registers
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_r    <= adcs_pkg::ST_IDLE;
            ctrl_r  <= adcs_pkg::RST_CTRL;
            cfg_r   <= adcs_pkg::RST_CFG;
            ph_r    <= 9'h000;
            per_r   <= 4'h0;
            trial_r <= 12'h000;
            resv_r  <= 12'h000;
            dac_r   <= 12'h000;
            flag_r  <= 1'b0;
        end else begin
            st_r    <= st_nxt;
            ctrl_r  <= ctrl_nxt;
            ph_r    <= ph_nxt;
            per_r   <= per_nxt;
            trial_r <= trial_nxt;
            resv_r  <= resv_nxt;
            dac_r   <= resv_nxt | trial_nxt;
            if (cfg_we) begin
                cfg_r <= {hwdata[7:4], 4'h0};
            end
            // A completion in the clearing cycle keeps the flag set
            flag_r <= done_set | (flag_r & ~(stat_we & hwdata[0]));
        end
    end

    // Results survive reset
    always_ff @(posedge core_clk) begin
        if (res_we) begin
            if (cfg_r.justify) begin
                res_hi_r <= {4'h0, resv_nxt[11:8]};
                res_lo_r <= resv_nxt[7:0];
            end else begin
                res_hi_r <= resv_nxt[11:4];
                res_lo_r <= {resv_nxt[3:0], 4'h0};
            end
        end
    end

    assign hrdata               = hrdata_r;
    assign hreadyout            = hreadyout_r;
    assign hresp                = hresp_r;
    assign port_pin_out         = out_r;
    assign port_pin_oe          = oe_r;
    assign port_ibuf_en         = ibuf_r;
    assign ana_chan             = ctrl_r.chan;
    assign dac_code             = dac_r;
    assign conv_busy            = ctrl_r.go;
    assign conversion_done_flag = flag_r;
endmodule : adcs_top

// ---- dv/adcs_asserts.sv ----
`timescale 1ns/100ps
module adcs_asserts (
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [11:0] dac_code,
    input wire logic        conv_busy,
    input wire logic        conversion_done_flag
);
    logic        take;
    logic        stat_wr_r;
    logic [12:0] busy_cnt_r;
    assign take = hsel && htrans[1] && hready;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            stat_wr_r  <= 1'b0;
            busy_cnt_r <= 13'h0000;
        end else begin
            stat_wr_r  <= take && hwrite && (haddr[7:0] == 8'h24);
            busy_cnt_r <= conv_busy ? busy_cnt_r + 13'h0001 : 13'h0000;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence s_rd_wait;
        !hreadyout ##1 hreadyout;
    endsequence
    sequence s_done;
        $rose(conversion_done_flag);
    endsequence
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("bus response not okay");
    a_write_nowait: assert property (take && hwrite |=> hreadyout)
        else $error("write stalled");
    a_read_wait: assert property (take && !hwrite |=> s_rd_wait)
        else $error("read wait state wrong");
    a_flag_in_conv: assert property (s_done |-> conv_busy)
        else $error("done flag set outside conversion");
    a_conv_length: assert property (s_done |-> busy_cnt_r >= 13'h0019)
        else $error("conversion too short");
    a_go_clears: assert property (s_done |-> ##[1:200] !conv_busy)
        else $error("go bit not cleared after done");
    a_flag_sticky: assert property ($fell(conversion_done_flag)
        |-> $past(stat_wr_r)) else $error("done flag lost");
    a_msb_trial: assert property ($rose(conv_busy)
        |-> ##[1:300] dac_code == 12'h800) else $error("no msb trial");
endmodule : adcs_asserts

bind adcs_top adcs_asserts u_adcs_asserts (
    .core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .dac_code(dac_code),
    .conv_busy(conv_busy), .conversion_done_flag(conversion_done_flag)
);

// ---- dv/tb_adc_conversion_sequencer.sv ----
`timescale 1ns/100ps
module tb_adc_conversion_sequencer;
    logic        core_clk = 0;
    logic        rst      = 1;
    logic [31:0] haddr    = 0;
    logic [1:0]  htrans   = 0;
    logic        hwrite   = 0;
    logic [31:0] hwdata   = 0;
    logic [15:0] pin_in   = 0;
    logic        rc_osc   = 0;
    logic        cmp_in   = 0;
    logic        rd_dp    = 0;
    logic        rdy_s    = 1;
    logic [31:0] hrdata, ctl;
    logic        hreadyout, hresp, conv_busy, done_flag, ir;
    logic [15:0] pin_oe, ibuf_en, pin_out;
    logic [11:0] dac_code, vin;
    logic [7:0]  ma, mb, d, hi, lo;
    logic [5:0]  an;
    logic [2:0]  chan;
    logic [1:0]  sel;
    logic [31:0] exp_q [$];
    logic [2:0]  rf [4] = '{3'h0, 3'h1, 3'h3, 3'h5};
    logic [7:0]  fm [4] = '{8'h00, 8'h0C, 8'h08, 8'h04};
    int          num_errors = 0, samples_checked = 0, seed = 17593, n, p;

    adcs_top DUT (.core_clk(core_clk), .rst(rst), .hsel(1'b1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .port_pin_in(pin_in),
        .port_pin_out(pin_out), .port_pin_oe(pin_oe),
        .port_ibuf_en(ibuf_en), .rc_osc(rc_osc), .cmp_in(cmp_in),
        .ana_chan(chan), .dac_code(dac_code),
        .conv_busy(conv_busy), .conversion_done_flag(done_flag));

    always #5 core_clk = ~core_clk;
    always @(negedge core_clk) rdy_s = hreadyout;
    // Comparator of an ideal input: keep the trial bit while code <= input
    always @(posedge core_clk) cmp_in <= (dac_code <= vin);
    always @(posedge core_clk) if ($time % 30 < 10) rc_osc <= ~rc_osc;
    always @(posedge core_clk) if (rd_dp && rdy_s) chk(hrdata, exp_q.pop_front());

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] dt);
        haddr  <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge core_clk); while (!rdy_s);
        htrans <= 2'h0;
        hwdata <= dt;
        rd_dp  <= !w;
        do @(posedge core_clk); while (!rdy_s);
        rd_dp  <= 1'b0;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] dt);
        bus(a, 1'b1, dt);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(a, 1'b0, 32'h0);
    endtask : rd

    task results;
        $display("checks=%0d errors=%0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : results

    initial begin
        repeat (30000) @(posedge core_clk);
        num_errors++;
        results();
    end

    initial begin
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        rd(8'h00, 32'h0);
        rd(8'h04, 32'h0);
        rd(8'h10, 32'h3F);
        rd(8'h14, 32'hFF);
        rd(8'h24, 32'h0);
        wr(8'h30, 32'hFF);
        rd(8'h30, 32'h0);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            pin_in <= 16'($random(seed));
            an = 6'($random(seed));
            d  = 8'($random(seed));
            ma = {4'h0, an[3:0]} | fm[i];
            mb = {6'h0, an[5:4]};
            wr(8'h10, {26'h0, an});
            wr(8'h04, {24'h0, 1'b0, rf[i], 4'h0});
            wr(8'h14, {24'h0, d});
            wr(8'h1C, {24'h0, d});
            repeat (4) @(posedge core_clk);
            rd(8'h1C, {24'h0, pin_in[7:0] & ~ma});
            rd(8'h20, {24'h0, pin_in[15:8] & ~mb});
            chk({16'h0, ibuf_en}, {16'h0, ~mb, ~ma});
            chk({16'h0, pin_oe}, {24'h0, ~d});
            chk({16'h0, pin_out}, {24'h0, d});
        end
        $display("test pins done");
        wr(8'h00, 32'h05);
        rd(8'h00, 32'h01);
        $display("test on with go done");
        for (int k = 0; k < 7; k++) begin
            ir  = (k > 3);
            sel = ir ? 2'(k - 4) : 2'(k);
            p   = (2 << (2 * sel)) * (ir ? 8 : 1);
            vin = 12'($random(seed));
            ctl = {24'h0, sel, 3'(k), 3'h1};
            wr(8'h24, 32'h1);
            wr(8'h04, {24'h0, k[0], ir ? 3'h2 : 3'h0, 4'h0});
            wr(8'h00, ctl);
            repeat (3 * p) @(posedge core_clk);
            wr(8'h00, ctl | 32'h4);
            n = 0;
            while (!done_flag) begin
                @(negedge core_clk);
                n++;
            end
            // The negedge that sees the flag lies half a cycle past its edge
            if (sel != 2'h3) chk(n - 1, 13 * p);
            chk({29'h0, chan}, k);
            n = 0;
            while (conv_busy) begin
                @(negedge core_clk);
                n++;
            end
            if (sel != 2'h3) chk(n, p / 2);
            @(posedge core_clk);
            hi = k[0] ? {4'h0, vin[11:8]} : vin[11:4];
            lo = k[0] ? vin[7:0] : {vin[3:0], 4'h0};
            rd(8'h08, {24'h0, hi});
            rd(8'h0C, {24'h0, lo});
            rd(8'h24, 32'h1);
            rd(8'h00, ctl);
        end
        $display("test conversions done");
        wr(8'h24, 32'h1);
        wr(8'h04, 32'h0);
        vin = 12'($random(seed));
        wr(8'h00, 32'h41);
        wr(8'h00, 32'h45);
        // Abort lands mid sixth period: four bits resolved
        repeat (42) @(posedge core_clk);
        wr(8'h00, 32'h41);
        repeat (20) @(posedge core_clk);
        hi = {vin[11:8], 4'h0};
        rd(8'h08, {24'h0, hi});
        rd(8'h0C, 32'h0);
        rd(8'h24, 32'h0);
        rd(8'h00, 32'h41);
        $display("test abort done");
        wr(8'h00, 32'h45);
        repeat (20) @(posedge core_clk);
        rst <= 1'b1;
        @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        rd(8'h00, 32'h0);
        rd(8'h08, {24'h0, hi});
        rd(8'h0C, 32'h0);
        $display("test reset abort done");
        results();
    end
endmodule : tb_adc_conversion_sequencer
